// >>> hw/timestamp_pkg.sv
package timestamp_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 50;       // 20 MHz system clock
  localparam int unsigned TICK_PERIOD_NS = 25000;    // Nominal tick, 25 us
  localparam int unsigned PULSE_NS       = 75000;    // Pin pulse, 75 us
  localparam int unsigned EARLY_NS       = 6400000;  // Warning lead, 6.4 ms

  // Tick and pulse cycle counts round down, never below one cycle
  localparam int unsigned TICK_CYCLES  = (TICK_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
                                         TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned PULSE_CYCLES = (PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                         PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned EARLY_TICKS  = EARLY_NS / TICK_PERIOD_NS;

  // ****************************************************************
  // Rate trim: factor (1 + 0.0015*trim) = (TRIM_DEN + TRIM_NUM*trim) / TRIM_DEN
  // ****************************************************************
  localparam int unsigned TRIM_DEN    = 2000;
  localparam int unsigned TRIM_NUM    = 3;
  localparam int unsigned PHASE_LIMIT = TICK_CYCLES * TRIM_DEN;
  localparam int unsigned PHASE_W     = 21;

  // Base output rate is the tick rate divided by six (40000/6 = 6667 Hz)
  localparam logic [2:0] BASE_DIV_LAST = 3'h5;
  localparam int unsigned RATE_CODES   = 10;  // Coefficients 512 down to 1

  // ****************************************************************
  // Count limits and reset values
  // ****************************************************************
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_MAX   = 32'hffff_ffff;
  localparam logic [31:0] COUNT_WARN  = COUNT_MAX - 32'(EARLY_TICKS) + 32'h0000_0001;
  localparam logic [7:0]  CLEAR_MAGIC = 8'haa;

  // ****************************************************************
  // Register selects on the byte port
  // ****************************************************************
  localparam logic [2:0] SEL_COUNT_BYTE0 = 3'h0;
  localparam logic [2:0] SEL_COUNT_BYTE1 = 3'h1;
  localparam logic [2:0] SEL_COUNT_BYTE2 = 3'h2;
  localparam logic [2:0] SEL_COUNT_BYTE3 = 3'h3;
  localparam logic [2:0] SEL_ALL_EVENT   = 3'h4;
  localparam logic [2:0] SEL_TRIM        = 3'h5;
  localparam int unsigned EVENT_FLAG_BIT = 7;  // Flag position in event source byte

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] sel;
    logic [7:0] wdata;
  } reg_access_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] stamp;
  } stamp_word_t;

endpackage

// >>> hw/timestamp_counter.sv
`timescale 1ns/1ps
module timestamp_counter (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       nrst,
  // Control bits
  input  wire logic                       timestamp_en,
  input  wire logic                       accel_power_down,
  input  wire logic                       gyro_power_down,
  input  wire logic                       overrun_route_pin2,
  input  wire logic                       batch_stamp_en,
  input  wire logic [3:0]                 output_rate,
  // Factory trim value
  input  wire logic [7:0]                 rate_trim,
  // Byte register port
  input  wire timestamp_pkg::reg_access_t reg_access,
  output logic [7:0]                      reg_rdata,
  output logic                            reg_rvalid,
  // Status and events
  output logic [31:0]                     count_value,
  output logic [7:0]                      rate_trim_reg,
  output logic                            near_overrun_flag,
  output logic                            irq_pin2,
  output logic                            rate_tick,
  // FIFO feed
  output timestamp_pkg::stamp_word_t      fifo_stamp
);

  // ****************************************************************
  // Run control
  // ****************************************************************
  logic        running;
  logic        clear_req;
  logic        read_event;
  logic        read_byte0;

  // Frozen when disabled or when both sensors sleep
  assign running    = timestamp_en && !(accel_power_down && gyro_power_down);
  assign clear_req  = reg_access.wr && (reg_access.sel == timestamp_pkg::SEL_COUNT_BYTE2)
                      && (reg_access.wdata == timestamp_pkg::CLEAR_MAGIC);
  assign read_event = reg_access.rd && (reg_access.sel == timestamp_pkg::SEL_ALL_EVENT);
  assign read_byte0 = reg_access.rd && (reg_access.sel == timestamp_pkg::SEL_COUNT_BYTE0);

  // ****************************************************************
  // Trimmed tick generator
  // ****************************************************************
  logic [timestamp_pkg::PHASE_W-1:0] phase_q;
  logic [timestamp_pkg::PHASE_W-1:0] phase_d;
  logic [timestamp_pkg::PHASE_W-1:0] phase_step;
  logic [timestamp_pkg::PHASE_W-1:0] phase_sum;
  logic                              tick;

  // Step is TRIM_DEN + TRIM_NUM*trim; signed trim kept in range 1616..2381
  assign phase_step = timestamp_pkg::PHASE_W'(signed'(timestamp_pkg::TRIM_DEN)
                      + signed'(timestamp_pkg::TRIM_NUM) * signed'(rate_trim));
  assign phase_sum  = phase_q + phase_step;
  assign tick       = running
                      && (phase_sum >= timestamp_pkg::PHASE_W'(timestamp_pkg::PHASE_LIMIT));
  assign phase_d    = !running ? phase_q :
                      tick ? phase_sum - timestamp_pkg::PHASE_W'(timestamp_pkg::PHASE_LIMIT) :
                      phase_sum;

  // Fractional accumulator keeps the average period exact without a divider
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase_q <= '0;
    end else if (clear_req) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ****************************************************************
  // Timestamp counter
  // ****************************************************************
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic        warn_hit;

  // Natural 32-bit overflow wraps FFFFFFFF to zero
  assign count_d  = clear_req ? timestamp_pkg::COUNT_RESET :
                    tick ? count_q + 32'h0000_0001 : count_q;
  assign warn_hit = tick && (count_d == timestamp_pkg::COUNT_WARN);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_q <= timestamp_pkg::COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  // Visible copy of the live count
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_value <= timestamp_pkg::COUNT_RESET;
    end else begin
      count_value <= count_d;
    end
  end

  // ****************************************************************
  // Read snapshot
  // ****************************************************************
  logic [31:0] snap_q;
  logic [31:0] snap_d;
  logic [7:0]  snap_bytes [4];

  // Byte0 read captures all four bytes so a burst never mixes two counts
  assign snap_d = read_byte0 ? count_q : snap_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      snap_q <= timestamp_pkg::COUNT_RESET;
    end else begin
      snap_q <= snap_d;
    end
  end

  // Byte lanes, byte3 most significant
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign snap_bytes[i] = (i == 0) ? count_q[7:0] : snap_q[8*i +: 8];
  end

  // ****************************************************************
  // Near-overrun flag
  // ****************************************************************
  logic flag_d;

  // A warning landing on the clearing read wins over the clear
  assign flag_d = warn_hit ? 1'b1 : read_event ? 1'b0 : near_overrun_flag;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      near_overrun_flag <= 1'b0;
    end else begin
      near_overrun_flag <= flag_d;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [7:0] rdata_d;

  // Event source read shows the flag before its clear takes effect
  assign rdata_d = (reg_access.sel == timestamp_pkg::SEL_COUNT_BYTE0) ? snap_bytes[0] :
                   (reg_access.sel == timestamp_pkg::SEL_COUNT_BYTE1) ? snap_bytes[1] :
                   (reg_access.sel == timestamp_pkg::SEL_COUNT_BYTE2) ? snap_bytes[2] :
                   (reg_access.sel == timestamp_pkg::SEL_COUNT_BYTE3) ? snap_bytes[3] :
                   (reg_access.sel == timestamp_pkg::SEL_ALL_EVENT)
                     ? 8'(near_overrun_flag) << timestamp_pkg::EVENT_FLAG_BIT :
                   (reg_access.sel == timestamp_pkg::SEL_TRIM) ? rate_trim_reg :
                   8'h00;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_access.rd ? rdata_d : reg_rdata;
      reg_rvalid <= reg_access.rd;
    end
  end

  // Trim is sampled every cycle; it is a static factory value
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rate_trim_reg <= 8'h00;
    end else begin
      rate_trim_reg <= rate_trim;
    end
  end

  // ****************************************************************
  // Pin2 pulse
  // ****************************************************************
  logic [10:0] pulse_cnt_q;
  logic [10:0] pulse_cnt_d;
  logic        pulse_start;

  assign pulse_start = warn_hit && overrun_route_pin2;
  assign pulse_cnt_d = pulse_start ? 11'(timestamp_pkg::PULSE_CYCLES) :
                       (pulse_cnt_q != 11'h000) ? pulse_cnt_q - 11'h001 : 11'h000;

  // Counter is loaded then drained, so the pin stays high PULSE_CYCLES cycles
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pulse_cnt_q <= 11'h000;
      irq_pin2    <= 1'b0;
    end else begin
      pulse_cnt_q <= pulse_cnt_d;
      irq_pin2    <= (pulse_cnt_d != 11'h000);
    end
  end

  // ****************************************************************
  // Output data rate divider
  // ****************************************************************
  logic [2:0] base_cnt_q;
  logic [2:0] base_cnt_d;
  logic       base_tick;
  logic [8:0] prescale_q;
  logic [8:0] prescale_d;
  logic [8:0] rate_mask;
  logic       rate_hit;

  // Base rate is the trimmed tick over six, so the trim carries through
  assign base_tick  = tick && (base_cnt_q == timestamp_pkg::BASE_DIV_LAST);
  assign base_cnt_d = !tick ? base_cnt_q :
                      (base_cnt_q == timestamp_pkg::BASE_DIV_LAST) ? 3'h0 : base_cnt_q + 3'h1;
  assign prescale_d = base_tick ? prescale_q + 9'h001 : prescale_q;
  // Code 0 selects coefficient 512, code 9 selects 1; codes above 9 act as 9
  assign rate_mask  = (output_rate >= 4'(timestamp_pkg::RATE_CODES)) ? 9'h000 :
                      9'h1ff >> output_rate;
  assign rate_hit   = base_tick && ((prescale_q & rate_mask) == rate_mask);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      base_cnt_q <= 3'h0;
      prescale_q <= 9'h000;
      rate_tick  <= 1'b0;
    end else begin
      base_cnt_q <= base_cnt_d;
      prescale_q <= prescale_d;
      rate_tick  <= rate_hit;
    end
  end

  // ****************************************************************
  // FIFO batching
  // ****************************************************************
  // One stamp per output rate tick, matching the sensor samples it goes with
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fifo_stamp <= '0;
    end else begin
      fifo_stamp.valid <= rate_hit && batch_stamp_en;
      fifo_stamp.stamp <= (rate_hit && batch_stamp_en) ? count_d : fifo_stamp.stamp;
    end
  end

endmodule

// >>> dv/timestamp_assertions.sv
`timescale 1ns/1ps
// ****
// Port checks
// ****
module timestamp_chk (
  // Clock and reset
  input wire logic                       clock,
  input wire logic                       nrst,
  // Controls
  input wire logic                       timestamp_en,
  input wire logic                       accel_power_down,
  input wire logic                       gyro_power_down,
  input wire logic                       overrun_route_pin2,
  input wire logic [7:0]                 rate_trim,
  input wire timestamp_pkg::reg_access_t reg_access,
  // Results
  input wire logic [7:0]                 reg_rdata,
  input wire logic                       reg_rvalid,
  input wire logic [31:0]                count_value,
  input wire logic [7:0]                 rate_trim_reg,
  input wire logic                       near_overrun_flag,
  input wire logic                       irq_pin2,
  input wire logic                       rate_tick,
  input wire timestamp_pkg::stamp_word_t fifo_stamp
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Held two edges so a pipelined enable cannot cause a false alarm
  logic frozen;
  assign frozen = !timestamp_en || (accel_power_down && gyro_power_down);
  sequence s_clear;
    reg_access.wr && reg_access.sel == timestamp_pkg::SEL_COUNT_BYTE2 &&
    reg_access.wdata == timestamp_pkg::CLEAR_MAGIC;
  endsequence
  sequence s_event_read;
    reg_access.rd && reg_access.sel == timestamp_pkg::SEL_ALL_EVENT;
  endsequence
  chk_read_answer: assert property (reg_access.rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  chk_no_spurious: assert property (!reg_access.rd |=> !reg_rvalid)
    else $error("answer without read");
  chk_magic_clear: assert property (s_clear |=> count_value == 32'h0)
    else $error("count not cleared");
  chk_count_frozen: assert property (frozen && $past(frozen) && !reg_access.wr
    |=> $stable(count_value)) else $error("count moved while stopped");
  chk_step_one: assert property ($changed(count_value) |->
    count_value == $past(count_value) + 32'h1 || count_value == 32'h0)
    else $error("count jumped");
  chk_trim_copy: assert property ($past(nrst) |-> rate_trim_reg == $past(rate_trim))
    else $error("trim copy wrong");
  chk_flag_moment: assert property ($rose(near_overrun_flag) |->
    count_value == 32'hffff_ff00) else $error("flag at wrong count");
  // A warning tick landing on the clearing read keeps the flag set
  chk_flag_clears: assert property (s_event_read ##0 near_overrun_flag
    ##0 count_value != 32'hffff_feff |=> !near_overrun_flag)
    else $error("flag not cleared by read");
  chk_event_data: assert property (s_event_read |=>
    reg_rdata[timestamp_pkg::EVENT_FLAG_BIT] == $past(near_overrun_flag))
    else $error("event byte wrong");
  chk_pin_pulse: assert property ($rose(irq_pin2) |-> near_overrun_flag &&
    $past(overrun_route_pin2) ##0 irq_pin2 [*8]) else $error("pin pulse wrong");
  chk_stamp_feed: assert property (fifo_stamp.valid |-> rate_tick &&
    fifo_stamp.stamp == count_value) else $error("stamp mismatch");
endmodule
bind timestamp_counter timestamp_chk u_chk (.clock, .nrst, .timestamp_en,
  .accel_power_down, .gyro_power_down, .overrun_route_pin2, .rate_trim,
  .reg_access, .reg_rdata, .reg_rvalid, .count_value, .rate_trim_reg,
  .near_overrun_flag, .irq_pin2, .rate_tick, .fifo_stamp);

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // ****
  // Bench signals
  // ****
  logic                       clock, nrst, en, apd, gpd, route, batch;
  logic [3:0]                 rate;
  logic [7:0]                 trim, trim_q, rdata, d;
  logic [31:0]                cnt;
  logic                       rvalid, flag, irq, rtick;
  timestamp_pkg::reg_access_t acc;
  timestamp_pkg::stamp_word_t stamp;
  int                         failures, tests_run, t1, t2;
  int                         cycles = 0;
  longint                     sum;

  timestamp_counter uut (.clock, .nrst, .timestamp_en(en), .accel_power_down(apd),
    .gyro_power_down(gpd), .overrun_route_pin2(route), .batch_stamp_en(batch),
    .output_rate(rate), .rate_trim(trim), .reg_access(acc), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .count_value(cnt), .rate_trim_reg(trim_q),
    .near_overrun_flag(flag), .irq_pin2(irq), .rate_tick(rtick), .fifo_stamp(stamp));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Phase model: trimmed steps summed since the last clear, one tick per million
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (!nrst || (acc.wr && acc.sel == 3'h2 && acc.wdata == 8'haa))
      sum <= 0;
    else if (en && !(apd && gpd))
      sum <= sum + 2000 + 3 * $signed(trim);
    if (cycles == 60000) begin
      failures++;
      $display("[FAIL] %0t run too long", $time);
      test_done();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [2:0] sel, output logic [7:0] v);
    acc <= '{1'b0, 1'b1, sel, 8'h00};
    @(posedge clock);
    acc.rd <= 1'b0;
    @(posedge clock);
    check({31'h0, rvalid}, 32'h1, "rvalid");
    v = rdata;
  endtask

  task automatic wr(input logic [2:0] sel, input logic [7:0] v);
    acc <= '{1'b1, 1'b0, sel, v};
    @(posedge clock);
    acc.wr <= 1'b0;
  endtask

  // Compares wait for mid-phase, so a one-cycle skew never flips a count
  task automatic snap();
    logic [7:0]  b [4];
    logic [31:0] e;
    do @(posedge clock);
    while (sum % 1000000 < 300000 || sum % 1000000 > 700000);
    e = 32'(sum / 1000000);
    check(cnt, e, "count");
    for (int i = 0; i < 4; i++) rd(3'(i), b[i]);
    check({b[3], b[2], b[1], b[0]}, e, "bytes");
  endtask

  task automatic next_stamp(output int t);
    int n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (stamp.valid !== 1'b1 && n < 7000);
    t = cycles;
    // A wait that ran out shows here as a missing valid
    check({31'h0, stamp.valid}, 32'h1, "stamp valid");
    check({31'h0, rtick}, 32'h1, "rate tick");
    check(stamp.stamp, 32'(sum / 1000000), "stamp");
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    {nrst, en, apd, gpd, route, batch} = '0;
    {rate, trim, acc, failures, tests_run} = '0;
    void'($urandom(20));
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    en <= 1'b1;
    route <= 1'b1;
    @(posedge clock);
    wr(3'h2, 8'haa);
    repeat (1200) @(posedge clock);
    snap();
    wr(3'h2, 8'h55);
    snap();
    wr(3'h2, 8'haa);
    snap();
    en <= 1'b0;
    repeat (1500) @(posedge clock);
    snap();
    {en, apd, gpd} <= 3'b111;
    repeat (1500) @(posedge clock);
    snap();
    gpd <= 1'b0;
    repeat (1500) @(posedge clock);
    snap();
    apd <= 1'b0;
    trim <= 8'($urandom_range(255));
    repeat (2500) @(posedge clock);
    snap();
    rd(3'h5, d);
    check({24'h0, d}, {24'h0, trim}, "trim");
    check({24'h0, trim_q}, {24'h0, trim}, "trim copy");
    rd(3'h4, d);
    check({24'h0, d}, 32'h0, "events");
    // Count is far from the top, so no warning and no pin pulse yet
    check({31'h0, flag}, 32'h0, "flag");
    check({31'h0, irq}, 32'h0, "pin2");
    rd(3'h6, d);
    check({24'h0, d}, 32'h0, "unused");
    // Rate codes 9 and 8 at zero trim: one stamp per 6 and 12 ticks
    trim <= 8'h00;
    batch <= 1'b1;
    for (int c = 9; c > 7; c--) begin
      rate <= 4'(c);
      wr(3'h2, 8'haa);
      next_stamp(t1);
      next_stamp(t2);
      check(32'(t2 - t1), 32'(3000 << (9 - c)), "rate");
    end
    test_done();
  end
endmodule
